//--- include/nswu_consts.svh
`ifndef NSWU_CONSTS_SVH
`define NSWU_CONSTS_SVH
// Operation
// - Swap exchanges nibbles, writes destination back
// - Swap: Z on zero, S=bit7, D/H kept
// - Inverted test: NOT dst AND mask, flags only
// - Mask ones select bits; operands untouched
// - Inverted test: Z, S=bit7, V=0, others kept
// - Test: dst AND mask, result not stored
// - Test: Z, S=bit7, V cleared, others kept
// - Wait halts execution; DMA still served
// - Any internal irq ends wait; flags kept
// - Exclusive-OR stored in destination, source kept

// APB register byte offsets
`define NSWU_OFF_INSTR   12'h000
`define NSWU_OFF_STATUS  12'h004
`define NSWU_OFF_FLAGS   12'h008
`define NSWU_OFF_WBASE   12'h00c
`define NSWU_OFF_RFADDR  12'h010
`define NSWU_OFF_RFDATA  12'h014

// Reset values
`define NSWU_RST_FLAGS   8'h00
`define NSWU_RST_WBASE   8'hc0

// Flag bit positions
`define NSWU_FL_C        7
`define NSWU_FL_Z        6
`define NSWU_FL_S        5
`define NSWU_FL_V        4
`define NSWU_FL_D        3
`define NSWU_FL_H        2

// Status bit positions
`define NSWU_ST_BUSY     0
`define NSWU_ST_WAIT     1
`define NSWU_ST_ILLEGAL  2
`define NSWU_ST_REFUSED  3

// Opcode groups (upper nibble) and forms (lower nibble)
`define NSWU_OPC_WAIT_FOR_IRQ        8'h3f
`define NSWU_GRP_SWAP                4'hf
`define NSWU_GRP_TEST_INVERTED_MASK  4'h6
`define NSWU_GRP_TEST_MASK           4'h7
`define NSWU_GRP_XOR                 4'hb
`define NSWU_FRM_R                   4'h0
`define NSWU_FRM_IR                  4'h1
`define NSWU_FRM_RR_W                4'h2
`define NSWU_FRM_RIR_W               4'h3
`define NSWU_FRM_RR                  4'h4
`define NSWU_FRM_RIR                 4'h5
`define NSWU_FRM_RIM                 4'h6

// Instruction lengths in CPU cycles
`define NSWU_CYC_SHORT   4'h6
`define NSWU_CYC_SWAP    4'h8
`define NSWU_CYC_LONG    4'ha
`endif

//--- include/nswu_pkg.sv
package nswu_pkg;
  // Execution sequencer states
  typedef enum logic [2:0] {ST_IDLE, ST_ISSUE, ST_CAPTURE, ST_EXEC, ST_PAD, ST_WAIT} nswu_state_t;
  // Decoded operation
  typedef enum logic [2:0] {
    OP_SWAP,
    OP_TEST_INVERTED_MASK,
    OP_TEST_MASK,
    OP_XOR,
    OP_WAIT_FOR_IRQ,
    OP_BAD
  } nswu_op_t;
  // DMA request into the register file
  typedef struct packed {
    logic       req;
    logic       we;
    logic [7:0] addr;
    logic [7:0] wdata;
  } nswu_dma_req_t;
  // DMA answer from the register file
  typedef struct packed {
    logic       gnt;
    logic       rvalid;
    logic [7:0] rdata;
  } nswu_dma_rsp_t;
endpackage

//--- rtl/nswu_regfile.sv
`timescale 1ns/10ps
module nswu_regfile (
  // Clock and reset
  input  wire logic       clock_i,
  input  wire logic       rst_n_i,
  // Single access port
  input  wire logic       we_i,
  input  wire logic [7:0] addr_i,
  input  wire logic [7:0] wdata_i,
  output logic      [7:0] rdata_o
);
  logic [7:0] mem_r [0:255];  // 256-byte register file, no reset

  // Write port
  always_ff @(posedge clock_i) begin
    if (we_i) begin
      mem_r[addr_i] <= wdata_i;
    end
  end

  // Registered read, old data on a same-cycle write
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_o <= 8'h00;
    end else begin
      rdata_o <= mem_r[addr_i];
    end
  end
endmodule

//--- rtl/nswu_top.sv
`timescale 1ns/10ps
`include "nswu_consts.svh"
module nswu_top (
  // Clock and reset
  input  wire logic                   clock_i,
  input  wire logic                   rst_n_i,
  // APB slave
  input  wire logic                   psel_i,
  input  wire logic                   penable_i,
  input  wire logic                   pwrite_i,
  input  wire logic [11:0]            paddr_i,
  input  wire logic [31:0]            pwdata_i,
  output logic      [31:0]            prdata_o,
  output logic                        pready_o,
  output logic                        pslverr_o,
  // Internal interrupts
  input  wire logic [7:0]             irq_i,
  input  wire logic                   fast_irq_i,
  // DMA port into the register file
  input  wire nswu_pkg::nswu_dma_req_t dma_req_i,
  output nswu_pkg::nswu_dma_rsp_t      dma_rsp_o,
  // Core status
  output logic                        busy_o,
  output logic                        halted_o,
  output logic      [7:0]             flags_o
);
  import nswu_pkg::*;

  nswu_state_t state_r;          // Sequencer state
  nswu_op_t    op_r;             // Operation in flight
  logic [7:0]  addr_r;           // Current fetch address, ends as dst
  logic        ind_r;            // Current address still a pointer
  logic        sel_src_r;        // Fetching the source operand
  logic [7:0]  dst_addr_r;       // Destination address held for later
  logic        dst_ind_r;        // Destination is indirect
  logic [7:0]  src_val_r;        // Source operand or mask
  logic [7:0]  dst_val_r;        // Destination operand
  logic [3:0]  cnt_r;            // Busy cycles so far
  logic [3:0]  target_r;         // Instruction length in cycles
  logic [7:0]  flags_r;          // Flag register
  logic [7:0]  wbase_r;          // Working register base
  logic [7:0]  rf_addr_r;        // Software access address
  logic [23:0] instr_r;          // Last accepted instruction word
  logic        illegal_r;        // Sticky: unknown opcode written
  logic        refused_r;        // Sticky: instruction written while busy
  logic        rd_pend_r;        // Software read waiting for memory
  logic        dma_rvalid_r;     // DMA read data valid

  // Decode outputs
  nswu_op_t    dec_op;
  logic [7:0]  dec_src_addr;
  logic        dec_src_ind;
  logic        dec_need_src;
  logic [7:0]  dec_dst_addr;
  logic        dec_dst_ind;
  logic [3:0]  dec_cyc;

  // APB decode
  logic        acc;
  logic        wr_acc;
  logic        hit_instr;
  logic        hit_status;
  logic        hit_flags;
  logic        hit_wbase;
  logic        hit_rfaddr;
  logic        hit_rfdata;
  logic        mapped;
  logic        start;
  logic        instr_wr;

  // Memory arbitration
  logic        exec_rd;
  logic        exec_wr;
  logic        exec_mem;
  logic        dma_gnt;
  logic        apb_gnt;
  logic        mem_we;
  logic [7:0]  mem_addr;
  logic [7:0]  mem_wdata;
  logic [7:0]  mem_rdata;

  // Datapath
  logic [7:0]  result;
  logic [7:0]  flags_nxt;
  logic        wake;

  // Pick apart the written instruction word
  logic [7:0]  opc;
  logic [7:0]  b1;
  logic [7:0]  b2;
  assign opc = pwdata_i[7:0];
  assign b1  = pwdata_i[15:8];
  assign b2  = pwdata_i[23:16];

  // Opcode and operand form decode
  always_comb begin
    dec_op       = OP_BAD;
    dec_src_addr = b1;
    dec_src_ind  = 1'b0;
    dec_need_src = 1'b0;
    dec_dst_addr = b2;
    dec_dst_ind  = 1'b0;
    dec_cyc      = `NSWU_CYC_LONG;
    if (opc == `NSWU_OPC_WAIT_FOR_IRQ) begin
      dec_op = OP_WAIT_FOR_IRQ;
    end else if (opc[7:4] == `NSWU_GRP_SWAP) begin
      // Single-operand form, R or IR
      dec_dst_addr = b1;
      dec_cyc      = `NSWU_CYC_SWAP;
      if (opc[3:0] == `NSWU_FRM_R || opc[3:0] == `NSWU_FRM_IR) begin
        dec_op      = OP_SWAP;
        dec_dst_ind = opc[0];
      end
    end else if (opc[7:4] == `NSWU_GRP_TEST_INVERTED_MASK || opc[7:4] == `NSWU_GRP_TEST_MASK ||
                 opc[7:4] == `NSWU_GRP_XOR) begin
      // Two-operand group; form picks bytes and indirection
      if (opc[7:4] == `NSWU_GRP_TEST_INVERTED_MASK) begin
        dec_op = OP_TEST_INVERTED_MASK;
      end else if (opc[7:4] == `NSWU_GRP_TEST_MASK) begin
        dec_op = OP_TEST_MASK;
      end else begin
        dec_op = OP_XOR;
      end
      unique case (opc[3:0])
        `NSWU_FRM_RR_W, `NSWU_FRM_RIR_W: begin
          // Working registers packed as dst|src nibbles
          dec_dst_addr = {wbase_r[7:4], b1[7:4]};
          dec_src_addr = {wbase_r[7:4], b1[3:0]};
          dec_src_ind  = opc[0];
          dec_need_src = 1'b1;
          dec_cyc      = `NSWU_CYC_SHORT;
        end
        `NSWU_FRM_RR, `NSWU_FRM_RIR: begin
          // Three bytes, source byte first
          dec_src_addr = b1;
          dec_dst_addr = b2;
          dec_src_ind  = opc[0];
          dec_need_src = 1'b1;
        end
        `NSWU_FRM_RIM: begin
          // Destination then immediate
          dec_dst_addr = b1;
        end
        default: begin
          // Unknown form in a known group
          dec_op = OP_BAD;
        end
      endcase
    end
  end

  // APB address decode; only aligned words are mapped
  assign acc        = psel_i & penable_i;
  assign wr_acc     = acc & pwrite_i;
  assign hit_instr  = paddr_i == `NSWU_OFF_INSTR;
  assign hit_status = paddr_i == `NSWU_OFF_STATUS;
  assign hit_flags  = paddr_i == `NSWU_OFF_FLAGS;
  assign hit_wbase  = paddr_i == `NSWU_OFF_WBASE;
  assign hit_rfaddr = paddr_i == `NSWU_OFF_RFADDR;
  assign hit_rfdata = paddr_i == `NSWU_OFF_RFDATA;
  assign mapped     = hit_instr | hit_status | hit_flags | hit_wbase | hit_rfaddr | hit_rfdata;
  assign instr_wr   = wr_acc & hit_instr;
  assign start      = instr_wr & (state_r == ST_IDLE) & (dec_op != OP_BAD);

  // Register file arbitration: sequencer, then DMA, then software
  assign exec_rd  = state_r == ST_ISSUE;
  assign exec_wr  = (state_r == ST_EXEC) & ((op_r == OP_SWAP) | (op_r == OP_XOR));
  assign exec_mem = exec_rd | exec_wr;
  assign dma_gnt  = dma_req_i.req & ~exec_mem;
  assign apb_gnt  = acc & hit_rfdata & ~exec_mem & ~dma_req_i.req & ~rd_pend_r;

  // Memory port steering
  always_comb begin
    mem_we    = 1'b0;
    mem_addr  = rf_addr_r;
    mem_wdata = pwdata_i[7:0];
    if (exec_mem) begin
      mem_we    = exec_wr;
      mem_addr  = addr_r;
      mem_wdata = result;
    end else if (dma_gnt) begin
      mem_we    = dma_req_i.we;
      mem_addr  = dma_req_i.addr;
      mem_wdata = dma_req_i.wdata;
    end else if (apb_gnt) begin
      mem_we    = pwrite_i;
    end
  end

  nswu_regfile u_regfile (
    .clock_i (clock_i),
    .rst_n_i (rst_n_i),
    .we_i    (mem_we),
    .addr_i  (mem_addr),
    .wdata_i (mem_wdata),
    .rdata_o (mem_rdata)
  );

  // Operation results; tests never reach memory
  always_comb begin
    unique case (op_r)
      OP_SWAP: result = {dst_val_r[3:0], dst_val_r[7:4]};
      OP_TEST_INVERTED_MASK: result = ~dst_val_r & src_val_r;
      OP_TEST_MASK:          result = dst_val_r & src_val_r;
      OP_XOR:  result = dst_val_r ^ src_val_r;
      default: result = 8'h00;
    endcase
  end

  // Flag update; C, D, H always carried over
  always_comb begin
    flags_nxt = flags_r;
    flags_nxt[`NSWU_FL_Z] = result == 8'h00;
    flags_nxt[`NSWU_FL_S] = result[7];
    // Swap leaves V as it was; the others clear it
    if (op_r != OP_SWAP) begin
      flags_nxt[`NSWU_FL_V] = 1'b0;
    end
  end

  // Any internal interrupt, fast one included, wakes the core
  assign wake = (|irq_i) | fast_irq_i;

  // Sequencer
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_r <= ST_IDLE;
    end else begin
      unique case (state_r)
        ST_IDLE: begin
          if (start) begin
            state_r <= (dec_op == OP_WAIT_FOR_IRQ) ? ST_WAIT : ST_ISSUE;
          end
        end
        ST_ISSUE: state_r <= ST_CAPTURE;
        ST_CAPTURE: begin
          // Last capture is the final destination byte
          if (!ind_r && !sel_src_r) begin
            state_r <= ST_EXEC;
          end else begin
            state_r <= ST_ISSUE;
          end
        end
        ST_EXEC, ST_PAD: begin
          // Hold busy until the documented length has run
          state_r <= (cnt_r >= target_r - 4'h1) ? ST_IDLE : ST_PAD;
        end
        ST_WAIT: begin
          // Execution stalls here; DMA keeps the memory
          if (wake) begin
            state_r <= ST_IDLE;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // Operand fetch: source first, then destination, pointers resolved
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      op_r       <= OP_BAD;
      addr_r     <= 8'h00;
      ind_r      <= 1'b0;
      sel_src_r  <= 1'b0;
      dst_addr_r <= 8'h00;
      dst_ind_r  <= 1'b0;
      src_val_r  <= 8'h00;
      dst_val_r  <= 8'h00;
      target_r   <= `NSWU_CYC_LONG;
    end else if (start) begin
      op_r       <= dec_op;
      dst_addr_r <= dec_dst_addr;
      dst_ind_r  <= dec_dst_ind;
      target_r   <= dec_cyc;
      sel_src_r  <= dec_need_src;
      // Immediate mask rides in the third byte
      src_val_r  <= b2;
      addr_r     <= dec_need_src ? dec_src_addr : dec_dst_addr;
      ind_r      <= dec_need_src ? dec_src_ind : dec_dst_ind;
    end else if (state_r == ST_CAPTURE) begin
      if (ind_r) begin
        // Pointer fetched; follow it once
        addr_r <= mem_rdata;
        ind_r  <= 1'b0;
      end else if (sel_src_r) begin
        src_val_r <= mem_rdata;
        sel_src_r <= 1'b0;
        addr_r    <= dst_addr_r;
        ind_r     <= dst_ind_r;
      end else begin
        dst_val_r <= mem_rdata;
      end
    end
  end

  // Busy cycle counter, first busy cycle reads zero
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_r <= 4'h0;
    end else if (start) begin
      cnt_r <= 4'h0;
    end else if (state_r != ST_IDLE && state_r != ST_WAIT && cnt_r != 4'hf) begin
      cnt_r <= cnt_r + 4'h1;
    end
  end

  // Flags: the execution edge beats a software write
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      flags_r <= `NSWU_RST_FLAGS;
    end else if (state_r == ST_EXEC) begin
      flags_r <= flags_nxt;
    end else if (wr_acc && hit_flags) begin
      flags_r <= pwdata_i[7:0];
    end
  end

  // Software-written configuration
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wbase_r   <= `NSWU_RST_WBASE;
      rf_addr_r <= 8'h00;
      instr_r   <= 24'h000000;
    end else begin
      if (wr_acc && hit_wbase) begin
        wbase_r <= pwdata_i[7:0];
      end
      if (wr_acc && hit_rfaddr) begin
        rf_addr_r <= pwdata_i[7:0];
      end
      if (start) begin
        instr_r <= pwdata_i[23:0];
      end
    end
  end

  // Sticky errors; a new event wins over write-one-to-clear
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      illegal_r <= 1'b0;
      refused_r <= 1'b0;
    end else begin
      if (instr_wr && state_r == ST_IDLE && dec_op == OP_BAD) begin
        illegal_r <= 1'b1;
      end else if (wr_acc && hit_status && pwdata_i[`NSWU_ST_ILLEGAL]) begin
        illegal_r <= 1'b0;
      end
      if (instr_wr && state_r != ST_IDLE) begin
        refused_r <= 1'b1;
      end else if (wr_acc && hit_status && pwdata_i[`NSWU_ST_REFUSED]) begin
        refused_r <= 1'b0;
      end
    end
  end

  // Read-side handshakes for memory-backed accesses
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd_pend_r    <= 1'b0;
      dma_rvalid_r <= 1'b0;
    end else begin
      rd_pend_r    <= apb_gnt & ~pwrite_i;
      dma_rvalid_r <= dma_gnt & ~dma_req_i.we;
    end
  end

  // APB answer; memory data reads take one extra cycle
  always_comb begin
    pready_o  = 1'b1;
    pslverr_o = acc & ~mapped;
    prdata_o  = 32'h00000000;
    if (hit_rfdata) begin
      pready_o = pwrite_i ? apb_gnt : rd_pend_r;
    end
    if (acc && !pwrite_i) begin
      if (hit_instr) begin
        prdata_o = {8'h00, instr_r};
      end else if (hit_status) begin
        prdata_o = {16'h0000, flags_r, 4'h0, refused_r, illegal_r,
                    state_r == ST_WAIT, state_r != ST_IDLE};
      end else if (hit_flags) begin
        prdata_o = {24'h000000, flags_r};
      end else if (hit_wbase) begin
        prdata_o = {24'h000000, wbase_r};
      end else if (hit_rfaddr) begin
        prdata_o = {24'h000000, rf_addr_r};
      end else if (hit_rfdata) begin
        prdata_o = {24'h000000, mem_rdata};
      end
    end
  end

  // Outward status and DMA answer
  assign dma_rsp_o.gnt    = dma_gnt;
  assign dma_rsp_o.rvalid = dma_rvalid_r;
  assign dma_rsp_o.rdata  = mem_rdata;
  assign busy_o           = state_r != ST_IDLE;
  assign halted_o         = state_r == ST_WAIT;
  assign flags_o          = flags_r;
endmodule

//--- verif/nswu_checker.sv
`timescale 1ns/10ps
`include "nswu_consts.svh"
module nswu_checker (
  // Clock and reset
  input wire logic                    clock_i,
  input wire logic                    rst_n_i,
  // APB slave
  input wire logic                    psel_i,
  input wire logic                    penable_i,
  input wire logic                    pwrite_i,
  input wire logic [11:0]             paddr_i,
  input wire logic [31:0]             pwdata_i,
  input wire logic [31:0]             prdata_o,
  input wire logic                    pready_o,
  input wire logic                    pslverr_o,
  // Interrupts and DMA
  input wire logic [7:0]              irq_i,
  input wire logic                    fast_irq_i,
  input wire nswu_pkg::nswu_dma_req_t dma_req_i,
  input wire nswu_pkg::nswu_dma_rsp_t dma_rsp_o,
  // Core status
  input wire logic                    busy_o,
  input wire logic                    halted_o,
  input wire logic [7:0]              flags_o
);
  import nswu_pkg::*;
  // Software write to the flag register; it may legally move flags at any time
  logic flags_wr;
  // Instruction accepted while idle
  logic start;
  assign flags_wr = psel_i && penable_i && pready_o && pwrite_i && (paddr_i == `NSWU_OFF_FLAGS);
  assign start    = psel_i && penable_i && pready_o && pwrite_i && (paddr_i == `NSWU_OFF_INSTR) && !busy_o;
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);

  a_wait_entry: assert property (start && pwdata_i[7:0] == 8'h3f |=> halted_o && busy_o)
    else $error("wait not entered after wait instruction");
  a_wait_dma: assert property (halted_o && dma_req_i.req |-> dma_rsp_o.gnt)
    else $error("dma refused during wait");
  a_dma_read: assert property (dma_req_i.req && dma_rsp_o.gnt && !dma_req_i.we |=> dma_rsp_o.rvalid)
    else $error("dma read gave no rvalid");
  a_wait_release: assert property (halted_o && (|irq_i || fast_irq_i) |=> !halted_o)
    else $error("wait not left after interrupt");
  a_wait_flags: assert property (halted_o && !flags_wr |=> $stable(flags_o))
    else $error("flags moved during wait");
  a_idle_flags: assert property (!busy_o && !flags_wr |=> $stable(flags_o))
    else $error("flags moved while idle");
  a_flags_kept: assert property (!flags_wr |=> $stable(flags_o[7]) && $stable(flags_o[3:0]))
    else $error("carry, decimal or half-carry changed");
  a_swap_len: assert property (start && pwdata_i[7:0] == 8'hf0 |=> busy_o [*8] ##1 !busy_o)
    else $error("swap length wrong");
  a_long_len: assert property (start && pwdata_i[7:0] == 8'hb4 |=> busy_o [*8] ##1 busy_o [*2] ##1 !busy_o)
    else $error("long form length wrong");
  a_short_len: assert property (start && pwdata_i[7:0] == 8'h72 |=> busy_o [*6] ##1 !busy_o)
    else $error("short form length wrong");

  // Main scenarios reached
  c_start: cover property (start ##1 busy_o);
  c_wake: cover property ($fell(halted_o));
  c_dma_wait: cover property (halted_o && dma_rsp_o.rvalid);
endmodule

bind nswu_top nswu_checker u_nswu_checker (
  .clock_i    (clock_i),
  .rst_n_i    (rst_n_i),
  .psel_i     (psel_i),
  .penable_i  (penable_i),
  .pwrite_i   (pwrite_i),
  .paddr_i    (paddr_i),
  .pwdata_i   (pwdata_i),
  .prdata_o   (prdata_o),
  .pready_o   (pready_o),
  .pslverr_o  (pslverr_o),
  .irq_i      (irq_i),
  .fast_irq_i (fast_irq_i),
  .dma_req_i  (dma_req_i),
  .dma_rsp_o  (dma_rsp_o),
  .busy_o     (busy_o),
  .halted_o   (halted_o),
  .flags_o    (flags_o)
);

//--- verif/nswu_top_tb.sv
`timescale 1ns/10ps
`include "nswu_consts.svh"
module nswu_top_tb;
  import nswu_pkg::*;
  // Stimulus and observed signals
  logic          clk;
  logic          rst_n;
  logic          psel, penable, pwrite, pready, pslverr, err, busy, halted, fast_irq;
  logic [11:0]   paddr;
  logic [31:0]   pwdata, prdata, rdv;
  logic [7:0]    irq, flags, opc, b1, b2, dv, sv, pv, ed, ef;
  nswu_dma_req_t dma_req;
  nswu_dma_rsp_t dma_rsp;
  int            n_errors, tests_run;
  // Rows: opcode, byte1, byte2, dst, src, pointer, dst after, flags after (preset 9c)
  logic [63:0]   rows [17] = '{
    64'hf0_10_00_3e_11_11_e3_bc, 64'hf1_12_00_00_11_10_00_dc, 64'h64_11_10_2b_02_11_2b_cc,
    64'h66_10_80_2b_11_11_2b_ac, 64'h75_12_10_2b_23_11_2b_8c, 64'h72_01_00_2b_54_11_2b_cc,
    64'h73_02_00_c7_80_11_c7_ac, 64'hb2_01_00_c7_02_11_c5_ac, 64'hb4_11_10_2b_02_11_29_8c,
    64'hb5_12_10_2b_23_11_08_8c, 64'hb6_10_54_54_11_11_00_cc, 64'h62_01_00_c7_02_11_c7_cc,
    64'h63_02_00_c7_23_11_c7_8c, 64'h65_12_10_2b_23_11_2b_cc, 64'h74_11_10_2b_02_11_2b_8c,
    64'h76_10_54_2b_11_11_2b_cc, 64'hb3_02_00_c7_23_11_e4_ac};

  nswu_top u_nswu_top (
    .clock_i(clk), .rst_n_i(rst_n), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .irq_i(irq), .fast_irq_i(fast_irq), .dma_req_i(dma_req), .dma_rsp_o(dma_rsp),
    .busy_o(busy), .halted_o(halted), .flags_o(flags));

  // 250 MHz clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // One comparison, counted; mismatch reported at once
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // One APB transfer; request held until pready is seen at an edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 100);
    if (pready !== 1'b1) chk("pready", 32'h1, 32'h0);
    rdv = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Register file byte access through the address/data pair
  task automatic rf(input logic w, input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, `NSWU_OFF_RFADDR, {24'h0, a});
    apb(w, `NSWU_OFF_RFDATA, {24'h0, d});
  endtask

  // Bounded wait for the sequencer to go idle
  task automatic wait_idle;
    int n;
    n = 0;
    @(posedge clk);
    while (busy !== 1'b0 && n < 100) begin
      @(posedge clk);
      n++;
    end
    chk("busy idle", 32'h0, {31'h0, busy});
  endtask

  // Verdict and end of run
  task automatic end_sim;
    if (n_errors == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    end_sim();
  end

  // Main sequence
  initial begin
    rst_n = 1'b0;
    {psel, penable, pwrite, fast_irq} = 4'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    irq = 8'h00;
    dma_req = '0;
    n_errors = 0;
    tests_run = 0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    // Working registers moved onto the test bytes 10..12
    apb(1'b1, `NSWU_OFF_WBASE, 32'h10);
    foreach (rows[i]) begin
      {opc, b1, b2, dv, sv, pv, ed, ef} = rows[i];
      rf(1'b1, 8'h10, dv);
      rf(1'b1, 8'h11, sv);
      rf(1'b1, 8'h12, pv);
      apb(1'b1, `NSWU_OFF_FLAGS, 32'h9c);
      apb(1'b1, `NSWU_OFF_INSTR, {8'h00, b2, b1, opc});
      wait_idle();
      chk("flags_o", ef, flags);
      rf(1'b0, 8'h10, 8'h00);
      chk("dst", ed, rdv[7:0]);
      rf(1'b0, 8'h11, 8'h00);
      chk("src", sv, rdv[7:0]);
      rf(1'b0, 8'h12, 8'h00);
      chk("ptr", pv, rdv[7:0]);
    end
    // Wait state woken by a plain and by a fast interrupt, DMA served meanwhile
    for (int k = 0; k < 2; k++) begin
      apb(1'b1, `NSWU_OFF_FLAGS, 32'h63);
      apb(1'b1, `NSWU_OFF_INSTR, 32'h3f);
      repeat (4) @(posedge clk);
      chk("halted", 32'h1, halted);
      dma_req <= '{req: 1'b1, we: 1'b1, addr: 8'h20, wdata: 8'ha5};
      @(posedge clk);
      chk("gnt", 32'h1, dma_rsp.gnt);
      dma_req <= '{req: 1'b1, we: 1'b0, addr: 8'h20, wdata: 8'h00};
      @(posedge clk);
      dma_req <= '0;
      @(posedge clk);
      chk("rvalid", 32'h1, dma_rsp.rvalid);
      chk("rdata", 32'ha5, dma_rsp.rdata);
      repeat (8) @(posedge clk);
      chk("still halted", 32'h1, halted);
      if (k == 0) irq <= 8'h08;
      else fast_irq <= 1'b1;
      repeat (2) @(posedge clk);
      chk("woken", 32'h0, halted);
      chk("wait flags", 32'h63, flags);
      irq <= 8'h00;
      fast_irq <= 1'b0;
      wait_idle();
    end
    // Instruction written while busy is refused; the first one completes alone
    rf(1'b1, 8'h10, 8'h3e);
    apb(1'b1, `NSWU_OFF_INSTR, 32'h10f0);
    apb(1'b1, `NSWU_OFF_INSTR, 32'h5510b6);
    wait_idle();
    apb(1'b0, `NSWU_OFF_STATUS, 32'h0);
    chk("refused", 32'h1, rdv[3]);
    rf(1'b0, 8'h10, 8'h00);
    chk("single swap", 32'he3, rdv[7:0]);
    apb(1'b1, `NSWU_OFF_STATUS, 32'h8);
    apb(1'b0, `NSWU_OFF_STATUS, 32'h0);
    chk("refused cleared", 32'h0, rdv[3]);
    // Unknown opcode ignored, unmapped address errors
    apb(1'b1, `NSWU_OFF_INSTR, 32'hb7);
    @(posedge clk);
    chk("illegal idle", 32'h0, busy);
    apb(1'b0, `NSWU_OFF_STATUS, 32'h0);
    chk("illegal", 32'h1, rdv[2]);
    apb(1'b0, 12'h020, 32'h0);
    chk("pslverr", 32'h1, err);
    // Second reset in mid-run restores reset values
    rst_n <= 1'b0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    chk("flags rst", {24'h0, `NSWU_RST_FLAGS}, flags);
    chk("busy rst", 32'h0, busy);
    chk("halted rst", 32'h0, halted);
    apb(1'b0, `NSWU_OFF_WBASE, 32'h0);
    chk("WBASE rst", {24'h0, `NSWU_RST_WBASE}, rdv);
    apb(1'b0, `NSWU_OFF_FLAGS, 32'h0);
    chk("FLAGS rst", {24'h0, `NSWU_RST_FLAGS}, rdv);
    end_sim();
  end
endmodule
